// >>> power_mode_pkg.sv
// constants for the power-saving mode controller
package power_mode_pkg;
  localparam logic [7:0] PowerControlAddr  = 8'h87;
  localparam logic [7:0] PowerControlReset = 8'h00;
  localparam int         IdleBit           = 0;
  localparam int         PowerdownBit      = 1;
  localparam int         FlagZeroBit       = 2;
  localparam int         FlagOneBit        = 3;
  localparam int         SmodBit           = 7;
  localparam logic [7:0] WritableMask      = 8'h8f;
  // reserved bits 6..4 read as zero
  localparam int         OscPeriodsPerMc   = 12;
  localparam int         ResetMachineCycles = 2;
  localparam int         ClockHz           = 40000000;
  localparam int         OscStableMs       = 10;
  localparam int         OscStableCycles   = ClockHz / 1000 * OscStableMs;
  localparam logic [7:0] MapReadUnmapped   = 8'h00;
  typedef enum logic [1:0] {ModeRun, ModeIdle, ModePowerdown} power_mode_e;
endpackage

// >>> restart_timer.sv
// counter that holds the core off while the oscillator restarts
`timescale 1ns/10ps
module restart_timer #(
  parameter int Cycles = 16
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy
);
  logic [31:0] count_r;

  // loads on start, counts to zero; busy while nonzero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= 32'h0;
    end else if (start) begin
      count_r <= 32'(Cycles);
    end else if (count_r != 32'h0) begin
      count_r <= count_r - 32'h1;
    end
  end

  // start counts as busy so the cpu clock stays off during reset and the load cycle
  assign busy = start | (count_r != 32'h0);
endmodule

// >>> power_saving_mode_control.sv
// power-saving mode controller with power control register on avalon-mm
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
module power_saving_mode_control #(
  parameter int OscRestartCycles = power_mode_pkg::OscStableCycles,
  parameter int PortWidth        = 8
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // avalon-mm slave
  input  wire logic [7:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [7:0]           writedata,
  output logic      [7:0]           readdata,
  output logic                      waitrequest,
  // core side
  input  wire logic                 interruptPending,
  input  wire logic                 cpuAleActive,
  input  wire logic                 cpuProgramStoreStrobeActive,
  input  wire logic [PortWidth-1:0] portRegister,
  output logic                      cpuClockEnable,
  output logic                      peripheralClockEnable,
  output logic                      oscillatorEnable,
  output logic                      addressLatchStrobe,
  output logic                      program_store_strobe_n,
  output logic [PortWidth-1:0]      portOut,
  output logic                      idleActive,
  output logic                      powerdownActive
);
  power_mode_pkg::power_mode_e mode_r;
  logic [7:0]           power_control_r;
  logic [PortWidth-1:0] portHold_r;
  logic                 ackPhase_r;
  logic                 restartBusy;
  logic                 restartStart_r;
  logic                 regHit;
  logic                 writeTaken;
  logic                 idleReq;
  logic                 downReq;
  logic                 wakeIdle;

  // only the power control address is mapped
  assign regHit     = (address == power_mode_pkg::PowerControlAddr);
  // one wait cycle, answer on the second edge of a request
  assign waitrequest = (read | write) & ~ackPhase_r;
  assign writeTaken = write & ackPhase_r & regHit;
  assign idleReq    = writeTaken & writedata[power_mode_pkg::IdleBit];
  assign downReq    = writeTaken & writedata[power_mode_pkg::PowerdownBit];
  assign wakeIdle   = (mode_r == power_mode_pkg::ModeIdle) & interruptPending;

  // bus handshake phase; it runs in every mode, so accesses also complete in power-down
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ackPhase_r <= 1'b0;
    end else begin
      ackPhase_r <= (read | write) & ~ackPhase_r;
    end
  end

  // register contents; hardware clear of idle bit wins only over a stale value
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      power_control_r <= power_mode_pkg::PowerControlReset;
    end else if (writeTaken) begin
      power_control_r <= writedata & power_mode_pkg::WritableMask;
    end else if (wakeIdle) begin
      power_control_r[power_mode_pkg::IdleBit] <= 1'b0;
    end
  end

  // read data from flops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readdata <= 8'h00;
    end else if (read & ~ackPhase_r) begin
      readdata <= regHit ? power_control_r : power_mode_pkg::MapReadUnmapped;
    end
  end

  // mode sequencing; entry follows the completing write so it is the last one
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= power_mode_pkg::ModeRun;
    end else begin
      unique case (mode_r)
        power_mode_pkg::ModeRun: begin
          if (downReq) begin
            mode_r <= power_mode_pkg::ModePowerdown;
          end else if (idleReq) begin
            mode_r <= power_mode_pkg::ModeIdle;
          end
        end
        power_mode_pkg::ModeIdle: begin
          if (interruptPending) begin
            mode_r <= power_mode_pkg::ModeRun;
          end
        end
        power_mode_pkg::ModePowerdown: begin
          mode_r <= power_mode_pkg::ModePowerdown;
        end
        default: begin
          mode_r <= power_mode_pkg::ModeRun;
        end
      endcase
    end
  end

  // port values captured at idle entry; power-down follows the port register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      portHold_r <= '1;
    end else if (mode_r == power_mode_pkg::ModeRun) begin
      portHold_r <= portRegister;
    end
  end

  // pin values: frozen copy in idle, live port register otherwise
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      portOut <= '1;
    end else if (mode_r == power_mode_pkg::ModeIdle) begin
      portOut <= portHold_r;
    end else begin
      portOut <= portRegister;
    end
  end

  // oscillator restart after reset; cpu stays stopped until it settles
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      restartStart_r <= 1'b1;
    end else begin
      restartStart_r <= 1'b0;
    end
  end

  // long default count; a bench may shorten it through the parameter
  restart_timer #(
    .Cycles(OscRestartCycles)
  ) u_restart (
    .clock  (clock),
    .sys_rst(sys_rst),
    .start  (restartStart_r),
    .busy   (restartBusy)
  );

  // edges since reset, saturating so a long restart count cannot wrap
  logic [31:0] sinceReset_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sinceReset_r <= 32'h0;
    end else if (sinceReset_r != 32'hffffffff) begin
      sinceReset_r <= sinceReset_r + 32'h1;
    end
  end

  // mode decode
  assign idleActive      = (mode_r == power_mode_pkg::ModeIdle);
  assign powerdownActive = (mode_r == power_mode_pkg::ModePowerdown);
  // cpu clock gated in idle and power-down, peripherals only in power-down
  assign cpuClockEnable        = ~idleActive & ~powerdownActive & ~restartBusy;
  assign peripheralClockEnable = ~powerdownActive;
  assign oscillatorEnable      = ~powerdownActive;
  // strobes: idle inactive (latch low, store strobe high), power-down both low
  always_comb begin
    if (powerdownActive) begin
      addressLatchStrobe     = 1'b0;
      program_store_strobe_n = 1'b0;
    end else if (idleActive) begin
      addressLatchStrobe     = 1'b0;
      program_store_strobe_n = 1'b1;
    end else begin
      addressLatchStrobe     = cpuAleActive;
      program_store_strobe_n = ~cpuProgramStoreStrobeActive;
    end
  end

  // mode, strobe, port and flag checks
  AST_IDLE_ENTRY: assert property (@(posedge clock) disable iff (sys_rst)
    (idleReq & ~downReq & ~powerdownActive & ~idleActive) |=> idleActive)
    else $error("idle not entered after idle write");
  AST_DOWN_PRIORITY: assert property (@(posedge clock) disable iff (sys_rst)
    (downReq & ~idleActive) |=> powerdownActive)
    else $error("power-down not taken");
  AST_DOWN_STICKY: assert property (@(posedge clock) disable iff (sys_rst)
    powerdownActive |=> powerdownActive && !oscillatorEnable)
    else $error("power-down left without reset");
  AST_DOWN_STROBES: assert property (@(posedge clock) disable iff (sys_rst)
    powerdownActive |-> (!addressLatchStrobe && !program_store_strobe_n))
    else $error("strobes not low in power-down");
  AST_IDLE_STROBES: assert property (@(posedge clock) disable iff (sys_rst)
    idleActive |-> (!addressLatchStrobe && program_store_strobe_n && !cpuClockEnable))
    else $error("idle strobes or clock wrong");
  AST_IDLE_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
    (idleActive && interruptPending) |=> (!idleActive
      && !power_control_r[power_mode_pkg::IdleBit]))
    else $error("interrupt did not end idle");
  AST_IDLE_PERIPH: assert property (@(posedge clock) disable iff (sys_rst)
    idleActive |-> peripheralClockEnable)
    else $error("peripheral clock stopped in idle");
  AST_IDLE_PORTS: assert property (@(posedge clock) disable iff (sys_rst)
    (idleActive && $past(idleActive)) |-> $stable(portOut))
    else $error("ports moved in idle");
  AST_FLAGS: assert property (@(posedge clock) disable iff (sys_rst)
    writeTaken |=> power_control_r[3:2] == $past(writedata[3:2]))
    else $error("general flags not stored");
  AST_DOWN_PORTS: assert property (@(posedge clock) disable iff (sys_rst)
    (powerdownActive && $past(powerdownActive)) |-> portOut == $past(portRegister))
    else $error("ports not following register in power-down");

  // register bus checks
  AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
    (power_control_r & ~power_mode_pkg::WritableMask) == 8'h00)
    else $error("reserved power control bits set");
  // a master holds its request, so the second cycle always answers
  AST_BUS_ONE_WAIT: assert property (@(posedge clock) disable iff (sys_rst)
    ((read || write) && waitrequest) ##1 (read || write) |-> !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_READ_DATA: assert property (@(posedge clock) disable iff (sys_rst)
    (read && waitrequest && regHit) |=> readdata == $past(power_control_r))
    else $error("read data does not match power control");
  AST_READ_UNMAPPED: assert property (@(posedge clock) disable iff (sys_rst)
    (read && waitrequest && !regHit) |=> readdata == power_mode_pkg::MapReadUnmapped)
    else $error("unmapped read not zero");
  // read data must stand until the next read is seen
  AST_READ_STABLE: assert property (@(posedge clock) disable iff (sys_rst)
    !(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved without a read");
  // a stray write must not disturb the register
  AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
    (write && !waitrequest && !regHit && !idleActive) |=> $stable(power_control_r))
    else $error("unmapped write changed power control");
  AST_MODE_BITS: assert property (@(posedge clock) disable iff (sys_rst)
    writeTaken |=> power_control_r == ($past(writedata) & power_mode_pkg::WritableMask))
    else $error("written value not stored");
  // flags change only by software, never by a mode change
  AST_FLAG_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
    !writeTaken |=> $stable(power_control_r[3:2]))
    else $error("general flags changed without a write");

  // idle and run checks
  AST_IDLE_BIT: assert property (@(posedge clock) disable iff (sys_rst)
    idleActive |-> power_control_r[power_mode_pkg::IdleBit])
    else $error("idle mode without idle bit");
  AST_IDLE_STAYS: assert property (@(posedge clock) disable iff (sys_rst)
    (idleActive && !interruptPending) |=> idleActive)
    else $error("idle left without interrupt");
  // oscillator keeps running so a short reset can end idle
  AST_IDLE_OSC: assert property (@(posedge clock) disable iff (sys_rst)
    idleActive |-> oscillatorEnable)
    else $error("oscillator stopped in idle");
  AST_WAKE_CLOCK: assert property (@(posedge clock) disable iff (sys_rst)
    (idleActive && interruptPending && !restartBusy) |=> cpuClockEnable)
    else $error("cpu clock not back after wake");
  // outside the low-power modes the core drives the strobes
  AST_RUN_STROBES: assert property (@(posedge clock) disable iff (sys_rst)
    (!idleActive && !powerdownActive) |-> (addressLatchStrobe == cpuAleActive
      && program_store_strobe_n == !cpuProgramStoreStrobeActive))
    else $error("core strobes not passed through in run");
  AST_RUN_PERIPH: assert property (@(posedge clock) disable iff (sys_rst)
    !powerdownActive |-> peripheralClockEnable)
    else $error("peripheral clock stopped outside power-down");

  // power-down and restart checks
  AST_DOWN_CLOCKS: assert property (@(posedge clock) disable iff (sys_rst)
    powerdownActive |-> (!cpuClockEnable && !peripheralClockEnable))
    else $error("clocks running in power-down");
  AST_OSC_RUN: assert property (@(posedge clock) disable iff (sys_rst)
    !powerdownActive |-> oscillatorEnable)
    else $error("oscillator stopped outside power-down");
  // cpu clock stays off until the restart count has run out
  AST_RESTART_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    (sinceReset_r <= 32'(OscRestartCycles)) |-> !cpuClockEnable)
    else $error("cpu clock enabled before restart settled");
  AST_RESTART_DONE: assert property (@(posedge clock) disable iff (sys_rst)
    (sinceReset_r > 32'(OscRestartCycles) && !idleActive && !powerdownActive)
      |-> cpuClockEnable)
    else $error("cpu clock still off after restart");

  // scenario covers
  COV_IDLE: cover property (@(posedge clock) disable iff (sys_rst) idleReq ##1 idleActive);
  COV_WAKE: cover property (@(posedge clock) disable iff (sys_rst)
    idleActive ##1 !idleActive);
  COV_DOWN: cover property (@(posedge clock) disable iff (sys_rst) downReq ##1 powerdownActive);
  COV_BOTH: cover property (@(posedge clock) disable iff (sys_rst) idleReq && downReq);
  COV_RESTART: cover property (@(posedge clock) disable iff (sys_rst)
    restartBusy ##1 !restartBusy);
endmodule

// >>> reset_source.sv
// external reset source model that holds reset for a requested span
`timescale 1ns/10ps
module reset_source (
  input  wire logic        clock,
  input  wire logic        fire,
  input  wire logic [15:0] holdCycles,
  output logic             sysRst
);
  logic [15:0] left_r;
  // power-on hold is 16 clock cycles; the oscillator wait is left to the restart timer
  initial begin
    sysRst = 1'b1;
    left_r = 16'd16;
  end
  // hold length is the caller's choice, so idle and power-down exits differ
  always @(posedge clock) begin
    if (fire) begin
      sysRst <= 1'b1;
      left_r <= holdCycles;
    end else if (left_r != 16'd0) begin
      left_r <= left_r - 16'd1;
    end else begin
      sysRst <= 1'b0;
    end
  end
endmodule

// >>> power_saving_mode_control_tb.sv
// testbench for the power-saving mode controller
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module power_saving_mode_control_tb;
  logic        clock, sysRst, read, write, intPend, ale, pse, fire;
  logic [7:0]  address, writedata, readdata, portReg, portOut, q;
  logic        waitrequest, cpuEn, perEn, oscEn, aleOut, program_store_strobe, idle, down;
  logic [15:0] holdCycles;
  int          n_mismatch, samples_checked;

  power_saving_mode_control #(.OscRestartCycles(8), .PortWidth(8)) dut (
    .clock(clock), .sys_rst(sysRst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .interruptPending(intPend), .cpuAleActive(ale), .cpuProgramStoreStrobeActive(pse),
    .portRegister(portReg), .cpuClockEnable(cpuEn), .peripheralClockEnable(perEn),
    .oscillatorEnable(oscEn), .addressLatchStrobe(aleOut), .program_store_strobe_n(program_store_strobe),
    .portOut(portOut), .idleActive(idle), .powerdownActive(down));
  reset_source rsrc (.clock(clock), .fire(fire), .holdCycles(holdCycles), .sysRst(sysRst));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // one avalon transfer; held until waitrequest is seen low at a rising edge
  task automatic busOp(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(negedge clock);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    busOp(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask

  // span covers the hold plus the shortened oscillator restart
  task automatic doReset(input logic [15:0] h);
    @(posedge clock);
    fire <= 1'b1;
    holdCycles <= h;
    @(posedge clock);
    fire <= 1'b0;
    repeat (h + 16'd20) @(negedge clock);
  endtask

  task automatic intPulse();
    @(posedge clock) intPend <= 1'b1;
    @(posedge clock) intPend <= 1'b0;
    @(negedge clock);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    {read, write, intPend, fire} = 4'h0;
    {ale, pse} = 2'b11;
    address = 8'h00;
    writedata = 8'h00;
    portReg = 8'h5a;
    holdCycles = 16'h0000;
    wait (sysRst === 1'b0);
    repeat (12) @(negedge clock);
    rdChk(8'h87, 8'h00);
    `CHK({idle, down, oscEn, cpuEn}, 4'h3)
    `CHK({aleOut, program_store_strobe}, 2'b10)
    $display("test reset done");
    busOp(1'b1, 8'h87, 8'hfc);
    rdChk(8'h87, 8'h8c);
    busOp(1'b1, 8'h86, 8'h03);
    rdChk(8'h86, 8'h00);
    `CHK({idle, down}, 2'b00)
    $display("test flags done");
    busOp(1'b1, 8'h87, 8'h05);
    `CHK({idle, cpuEn, perEn, oscEn}, 4'hb)
    `CHK({aleOut, program_store_strobe}, 2'b01)
    @(posedge clock) portReg <= 8'ha5;
    @(negedge clock);
    `CHK(portOut, 8'h5a)
    rdChk(8'h87, 8'h05);
    intPulse();
    `CHK({idle, cpuEn}, 2'b01)
    rdChk(8'h87, 8'h04);
    $display("test idle done");
    busOp(1'b1, 8'h87, 8'h01);
    doReset(16'd24);
    rdChk(8'h87, 8'h00);
    `CHK({idle, cpuEn}, 2'b01)
    $display("test idle reset done");
    busOp(1'b1, 8'h87, 8'h0b);
    `CHK({down, idle, oscEn, perEn, cpuEn}, 5'h10)
    `CHK({aleOut, program_store_strobe}, 2'b00)
    `CHK(portOut, 8'ha5)
    @(posedge clock) portReg <= 8'h3c;
    repeat (2) @(negedge clock);
    `CHK(portOut, 8'h3c)
    intPulse();
    `CHK(down, 1'b1)
    doReset(16'd40);
    rdChk(8'h87, 8'h00);
    `CHK({down, oscEn, cpuEn}, 3'b011)
    $display("test power-down done");
    give_verdict();
  end
endmodule
